// [rtl/msc_pkg.sv]
// constants, pin bundle and state type shared by the sideband control block
// assumes a single 10 MHz clock and synchronous active-low reset
//
// Summary of operation
// R1: select input low: module answers two-wire management bus commands.
// R2: select input high: ignore all bus traffic, never ack or drive data.
// R3: host uses each module's select input to pick one module per transaction.
// R4: undriven select input reads high, so module stays deselected by default.
// R5: reset pin low beyond minimum pulse: full reset, user settings to defaults.
// R6: initialization interval starts at the rising edge ending the reset pulse.
// R7: host ignores status bits until reset completion is signalled.
// R8: reset completion shown by interrupt asserted with init pending bit clear.
// R9: after power-up the completion interrupt is raised without a reset pulse.
// R10: low power select high enters reduced power state, else ordinary state.
// R11: present output is driven low whenever the module is inserted.
// R12: interrupt output goes low on a fault or host-critical status.
// R13: host reads status over the serial bus to find the interrupt cause.
// R14: management memory answers at seven-bit bus address 1010000.
// R15: interrupt held until causing flags are read, released when none remain.
// R16: init pending set at every reset or power-up, cleared when init done.
`default_nettype none
package msc_pkg;

  localparam int CLK_NS        = 100;
  // minimum qualifying reset pulse, rounded up to whole cycles
  localparam int RESET_MIN_NS  = 10000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
  // initialization interval, rounded down to whole cycles
  localparam int INIT_NS       = 2000000;
  localparam int INIT_CYC      = INIT_NS / CLK_NS;

  localparam logic [6:0] DEV_ADDR    = 7'h50;
  localparam logic [7:0] ADDR_ID     = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_FLAGS  = 8'h03;
  localparam logic [7:0] ADDR_MASK   = 8'h64;

  // identifier value is arbitrary
  localparam logic [7:0] ID_VAL      = 8'h5a;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] FLAGS_RST   = 8'h00;
  localparam int         PEND_BIT    = 0;
  localparam int         DONE_BIT    = 0;
  localparam int         FAULT_W     = 7;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sel_n;
    logic rst_n;
    logic lp;
  } msc_pins_t;

  // pin levels assumed before the first sample
  localparam msc_pins_t PIN_RST = '{scl: 1'b1, sda: 1'b1, sel_n: 1'b1,
                                    rst_n: 1'b1, lp: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WR,
    ST_WACK,
    ST_RD,
    ST_RACK
  } msc_state_t;

endpackage
`default_nettype wire

// [rtl/msc_sync.sv]
// two-flop synchroniser for a bundle of asynchronous pin levels
// assumes each bit is an independent level; no bus coherency is implied
`timescale 1ns/1ps
`default_nettype none
module msc_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // refused at elaboration: a zero-width bundle has nothing to carry
  if (W < 1) begin : g_bad_w
    $error("msc_sync: W must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          meta_r <= RST_VAL[i];
          q[i]   <= RST_VAL[i];
        end else begin
          meta_r <= d[i];
          q[i]   <= meta_r;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [rtl/msc_top.sv]
// management sideband control: select-gated serial slave, module reset and
// init sequencing, low power, presence and interrupt
// assumes pins are asynchronous to clk; the bench resolves open-drain wires
`timescale 1ns/1ps
`default_nettype none
module msc_top
  import msc_pkg::*;
#(
  parameter int RESET_MIN_CYCLES = RESET_MIN_CYC,
  parameter int INIT_CYCLES      = INIT_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               module_select_n,
  input  wire logic               module_reset_n,
  input  wire logic               low_power_select,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  input  wire logic [FAULT_W-1:0] fault_evt,
  output logic                    sda_out,
  output logic                    sda_oe_n,
  output logic                    interrupt_n,
  output logic                    module_present_n,
  output logic                    low_power_active,
  output logic                    init_pending_flag
);

  localparam int RCW = $clog2(RESET_MIN_CYCLES + 1);
  localparam int ICW = $clog2(INIT_CYCLES + 1);
  localparam logic [RCW-1:0] RC_LAST = RCW'(RESET_MIN_CYCLES - 1);
  localparam logic [ICW-1:0] IC_LAST = ICW'(INIT_CYCLES - 1);

  if (RESET_MIN_CYCLES < 1) begin : g_bad_rmin
    $error("msc_top: RESET_MIN_CYCLES below 1");
  end
  if (INIT_CYCLES < 1) begin : g_bad_init
    $error("msc_top: INIT_CYCLES below 1");
  end

  msc_pins_t pins_raw;
  msc_pins_t pins_s;

  assign pins_raw = '{scl: scl_in, sda: sda_in, sel_n: module_select_n,
                      rst_n: module_reset_n, lp: low_power_select};

  // select resets to high so we stay deselected until the pin has been sampled [R4]
  msc_sync #(
    .W       ($bits(msc_pins_t)),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (pins_raw),
    .q     (pins_s)
  );

  // bus edge detection
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= pins_s.scl;
      sda_d_r <= pins_s.sda;
    end
  end

  assign scl_rise  = pins_s.scl & ~scl_d_r;
  assign scl_fall  = ~pins_s.scl & scl_d_r;
  assign bus_start = pins_s.scl & scl_d_r & sda_d_r & ~pins_s.sda;
  assign bus_stop  = pins_s.scl & scl_d_r & ~sda_d_r & pins_s.sda;

  // module reset pulse qualification
  logic [RCW-1:0] low_cnt_r;
  logic           armed_r;
  logic           full_rst;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      low_cnt_r <= '0;
      armed_r   <= 1'b0;
    end else if (!pins_s.rst_n) begin
      if (!armed_r) begin
        if (low_cnt_r == RC_LAST) begin
          armed_r <= 1'b1;                  // [R5]
        end else begin
          low_cnt_r <= low_cnt_r + RCW'(1);
        end
      end
    end else begin
      // a pulse shorter than the minimum is simply forgotten
      low_cnt_r <= '0;
      armed_r   <= 1'b0;
    end
  end

  // held for as long as a qualified pulse keeps the pin low
  assign full_rst = armed_r & ~pins_s.rst_n;

  // initialization interval
  logic [ICW-1:0] init_cnt_r;
  logic           init_busy_r;
  logic           init_done;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      init_busy_r <= 1'b1;                  // [R9] [R16]
      init_cnt_r  <= '0;
    end else if (full_rst) begin
      init_busy_r <= 1'b1;                  // [R16]
      init_cnt_r  <= '0;
    end else if (init_busy_r) begin
      // counting restarts from zero on the first cycle the pin reads high again [R6]
      if (init_cnt_r == IC_LAST) begin
        init_busy_r <= 1'b0;                // [R16]
      end else begin
        init_cnt_r <= init_cnt_r + ICW'(1);
      end
    end
  end

  assign init_done         = init_busy_r & ~full_rst & (init_cnt_r == IC_LAST);
  assign init_pending_flag = init_busy_r;

  // serial slave
  msc_state_t st_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic [2:0] cnt_r;
  logic       full_r;
  logic       rw_r;
  logic       first_r;
  logic       nack_r;
  logic       oe_n_r;
  logic [7:0] flags_r;
  logic [7:0] mask_r;
  logic       bus_go;
  logic       load_now;
  logic       wr_now;
  logic [7:0] rd_val;
  logic [7:0] rd_clr;
  logic [7:0] flag_set;

  assign bus_go   = ~pins_s.sel_n & ~bus_start & ~bus_stop & ~full_rst;
  assign load_now = bus_go & scl_fall &
                    (((st_r == ST_AACK) & rw_r) | ((st_r == ST_RACK) & ~nack_r));
  assign wr_now   = bus_go & scl_fall & (st_r == ST_WR) & full_r & ~first_r;

  always_comb begin
    case (ptr_r)
      ADDR_ID:     rd_val = ID_VAL;
      // host must not trust the rest while this bit is set [R7]
      ADDR_STATUS: rd_val = {7'h00, init_busy_r};
      ADDR_FLAGS:  rd_val = flags_r;        // [R13]
      ADDR_MASK:   rd_val = mask_r;
      default:     rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b || full_rst) begin
      st_r    <= ST_IDLE;
      sh_r    <= 8'h00;
      tx_r    <= 8'h00;
      ptr_r   <= 8'h00;
      cnt_r   <= 3'h0;
      full_r  <= 1'b0;
      rw_r    <= 1'b0;
      first_r <= 1'b1;
      nack_r  <= 1'b0;
      oe_n_r  <= 1'b1;
    end else if (pins_s.sel_n) begin
      st_r   <= ST_IDLE;                    // [R2]
      oe_n_r <= 1'b1;                       // [R2]
    end else if (bus_start) begin
      st_r   <= ST_ADDR;                    // [R1]
      cnt_r  <= 3'h0;
      full_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else if (bus_stop) begin
      st_r   <= ST_IDLE;
      oe_n_r <= 1'b1;
    end else begin
      case (st_r)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            sh_r   <= {sh_r[6:0], pins_s.sda};
            cnt_r  <= cnt_r + 3'h1;
            full_r <= (cnt_r == 3'h7);
          end else if (scl_fall && full_r) begin
            full_r <= 1'b0;
            if (st_r == ST_ADDR) begin
              if (sh_r[7:1] == DEV_ADDR) begin  // [R14]
                oe_n_r <= 1'b0;
                rw_r   <= sh_r[0];
                st_r   <= ST_AACK;
              end else begin
                st_r <= ST_IDLE;
              end
            end else begin
              oe_n_r  <= 1'b0;
              first_r <= 1'b0;
              ptr_r   <= first_r ? sh_r : ptr_r + 8'h01;
              st_r    <= ST_WACK;
            end
          end
        end
        ST_AACK, ST_RACK: begin
          if (scl_rise && st_r == ST_RACK) begin
            nack_r <= pins_s.sda;
          end else if (scl_fall) begin
            if (st_r == ST_AACK && !rw_r) begin
              oe_n_r  <= 1'b1;
              first_r <= 1'b1;
              cnt_r   <= 3'h0;
              st_r    <= ST_WR;
            end else if (st_r == ST_RACK && nack_r) begin
              oe_n_r <= 1'b1;
              st_r   <= ST_IDLE;
            end else begin
              tx_r   <= rd_val;
              oe_n_r <= rd_val[7];
              ptr_r  <= ptr_r + 8'h01;
              cnt_r  <= 3'h0;
              st_r   <= ST_RD;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              oe_n_r <= 1'b1;
              nack_r <= 1'b0;
              st_r   <= ST_RACK;
            end else begin
              oe_n_r <= tx_r[6];
              tx_r   <= {tx_r[6:0], 1'b0};
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            oe_n_r <= 1'b1;
            cnt_r  <= 3'h0;
            st_r   <= ST_WR;
          end
        end
        default: begin
          oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  // flags clear on read, but a new event in the same cycle survives [R15]
  assign rd_clr   = (load_now && ptr_r == ADDR_FLAGS) ? flags_r : 8'h00;
  assign flag_set = {fault_evt, init_done};   // [R8] [R12]

  always_ff @(posedge clk) begin
    if (!rst_b || full_rst) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~rd_clr) | flag_set;  // [R15]
    end
  end

  // user setting, back to default on every full reset
  always_ff @(posedge clk) begin
    if (!rst_b || full_rst) begin
      mask_r <= MASK_RST;                   // [R5]
    end else if (wr_now && ptr_r == ADDR_MASK) begin
      mask_r <= sh_r;
    end
  end

  // pin outputs, all registered
  logic sda_out_r;
  logic int_n_r;
  logic present_n_r;
  logic lp_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sda_out_r   <= 1'b0;
      int_n_r     <= 1'b1;
      present_n_r <= 1'b0;                  // [R11]
      lp_r        <= 1'b0;
    end else begin
      sda_out_r   <= 1'b0;
      // released once every unmasked flag has been read away [R12] [R15]
      int_n_r     <= ~|(flags_r & ~mask_r);
      present_n_r <= 1'b0;                  // [R11]
      lp_r        <= pins_s.lp;             // [R10]
    end
  end

  assign sda_out          = sda_out_r;
  assign sda_oe_n         = oe_n_r;
  assign interrupt_n      = int_n_r;
  assign module_present_n = present_n_r;
  assign low_power_active = lp_r;

endmodule
`default_nettype wire

// [verif/msc_host.sv]
// host-side model: bit-banged two-wire master
// assumes the bench resolves sda with a pull-up
`timescale 1ns/1ps
`default_nettype none
module msc_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_o
);
  // scl stands high between frames
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic q();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // also serves as repeated start
  task automatic start();
    sda_o = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_o = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_o = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_o = 1'b1;
    q();
  endtask
  task automatic bit_io(input logic v, output logic r);
    sda_o = v;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  // msb first; hack=1 acks a read byte
  task automatic xfer(input logic [7:0] tx, input logic hack,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(~hack, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// [verif/msc_top_props.sv]
// pin-level assertions for the sideband control block
// assumes the bind hands on the bench's short counts
`timescale 1ns/1ps
`default_nettype none
module msc_top_props
  import msc_pkg::*;
#(
  parameter int RESET_MIN_CYCLES = RESET_MIN_CYC,
  parameter int INIT_CYCLES      = INIT_CYC
) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               module_select_n,
  input wire logic               module_reset_n,
  input wire logic               low_power_select,
  input wire logic               scl_in,
  input wire logic               sda_in,
  input wire logic [FAULT_W-1:0] fault_evt,
  input wire logic               sda_out,
  input wire logic               sda_oe_n,
  input wire logic               interrupt_n,
  input wire logic               module_present_n,
  input wire logic               low_power_active,
  input wire logic               init_pending_flag
);
  int   rel_cnt;
  int   low_cnt;
  int   scl_idle;
  logic scl_q;
  always_ff @(posedge clk) begin
    if (!rst_b || !module_reset_n) rel_cnt <= 0;
    else if (rel_cnt < 100000) rel_cnt <= rel_cnt + 1;
  end
  always_ff @(posedge clk) begin
    if (!rst_b || module_reset_n) low_cnt <= 0;
    else if (low_cnt < 100000) low_cnt <= low_cnt + 1;
  end
  always_ff @(posedge clk) begin
    scl_q <= scl_in;
    if (scl_in != scl_q) scl_idle <= 0;
    else if (scl_idle < 1000) scl_idle <= scl_idle + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_desel_quiet: assert property (module_select_n [*6] |-> sda_oe_n)
    else $error("sda driven while deselected");
  chk_drive_low: assert property (!sda_oe_n |-> !sda_out && !$past(module_select_n, 6))
    else $error("bad sda drive");
  chk_present_low: assert property (!module_present_n)
    else $error("present not low");
  chk_lowpower_follow: assert property (
    $stable(low_power_select) [*5] |-> low_power_active == low_power_select)
    else $error("low power state wrong");
  chk_done_int: assert property ($fell(init_pending_flag) |=> !interrupt_n)
    else $error("no completion interrupt");
  chk_init_len: assert property ($fell(init_pending_flag) |->
    rel_cnt >= INIT_CYCLES && rel_cnt <= INIT_CYCLES + 6)
    else $error("init interval length wrong");
  chk_full_reset: assert property (low_cnt > RESET_MIN_CYCLES + 5 |->
    init_pending_flag && sda_oe_n && interrupt_n)
    else $error("long reset pulse not honoured");
  chk_int_release: assert property ($rose(interrupt_n) |-> scl_idle < 40 || low_cnt > 0)
    else $error("interrupt released without read");
endmodule
bind msc_top msc_top_props #(.RESET_MIN_CYCLES(RESET_MIN_CYCLES), .INIT_CYCLES(INIT_CYCLES))
  i_props (.*);
`default_nettype wire

// [verif/tb_msc_top.sv]
// self-checking bench for the sideband control block
// assumes shortened reset and init counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb_msc_top;
  import msc_pkg::*;
  localparam int RMIN = 5;
  localparam int INIT = 50;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sel_en = 1'b1;
  logic sel_drv = 1'b1;
  logic module_reset_n = 1'b1;
  logic low_power_select = 1'b0;
  logic [FAULT_W-1:0] fault_evt = '0;
  tri1 module_select_n;
  wire scl;
  wire host_sda;
  wire sda;
  logic sda_out, sda_oe_n, interrupt_n, module_present_n, low_power_active, init_pending_flag;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] d;
  always #50 clk = ~clk;
  // undriven select floats to the pull-up level
  assign module_select_n = sel_en ? sel_drv : 1'bz;
  assign sda = host_sda & (sda_oe_n | sda_out);
  msc_top #(.RESET_MIN_CYCLES(RMIN), .INIT_CYCLES(INIT)) i_dut (.clk(clk), .rst_b(rst_b),
    .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_select(low_power_select), .scl_in(scl), .sda_in(sda), .fault_evt(fault_evt),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .interrupt_n(interrupt_n),
    .module_present_n(module_present_n), .low_power_active(low_power_active),
    .init_pending_flag(init_pending_flag));
  msc_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_o(host_sda));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_int(input int bound);
    int n = 0;
    while (interrupt_n !== 1'b0 && n < bound) begin
      step(1);
      n++;
    end
    if (interrupt_n !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: interrupt wait timed out", $time);
      stop_test();
    end
  endtask
  task automatic addr(input logic [6:0] a, input logic rw, input logic exp);
    logic [7:0] r;
    logic k;
    i_host.start();
    i_host.xfer({a, rw}, 1'b0, r, k);
    `CHK(k, exp)
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    logic k;
    addr(DEV_ADDR, 1'b0, 1'b1);
    i_host.xfer(p, 1'b0, r, k);
    i_host.xfer(v, 1'b0, r, k);
    `CHK(k, 1'b1)
    i_host.stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    logic [7:0] r;
    logic k;
    addr(DEV_ADDR, 1'b0, 1'b1);
    i_host.xfer(p, 1'b0, r, k);
    addr(DEV_ADDR, 1'b1, 1'b1);
    i_host.xfer(8'hff, 1'b0, v, k);
    i_host.stop();
  endtask
  task automatic t_powerup();
    `CHK(init_pending_flag, 1'b1)
    `CHK(module_present_n, 1'b0)
    // status is only trusted once the completion interrupt shows
    wait_int(INIT + 20);
    `CHK(init_pending_flag, 1'b0)
  endtask
  task automatic t_select();
    sel_en = 1'b0;
    step(4);
    addr(DEV_ADDR, 1'b0, 1'b0);
    i_host.stop();
    sel_en = 1'b1;
    sel_drv = 1'b0;
    step(4);
    addr(7'h51, 1'b0, 1'b0);
    i_host.stop();
  endtask
  task automatic t_read();
    rd(ADDR_ID, d);
    `CHK(d, ID_VAL)
    rd(ADDR_FLAGS, d);
    `CHK(d, 8'h01)
    step(2);
    `CHK(interrupt_n, 1'b1)
    rd(ADDR_STATUS, d);
    `CHK(d, 8'h00)
  endtask
  // a read cut by deselection while its first data bit is driven, then a two-byte read with the first byte acked
  task automatic t_burst();
    logic [7:0] r;
    logic k;
    addr(DEV_ADDR, 1'b0, 1'b1);
    i_host.xfer(ADDR_ID, 1'b0, r, k);
    addr(DEV_ADDR, 1'b1, 1'b1);
    step(2);
    `CHK(sda_oe_n, ID_VAL[7])
    sel_drv = 1'b1;
    step(4);
    `CHK(sda_oe_n, 1'b1)
    sel_drv = 1'b0;
    step(4);
    i_host.stop();
    addr(DEV_ADDR, 1'b0, 1'b1);
    i_host.xfer(ADDR_ID, 1'b0, r, k);
    addr(DEV_ADDR, 1'b1, 1'b1);
    i_host.xfer(8'hff, 1'b1, r, k);
    `CHK(r, ID_VAL)
    i_host.xfer(8'hff, 1'b0, r, k);
    `CHK(r, 8'h00)
    i_host.stop();
  endtask
  task automatic t_fault();
    fault_evt = 7'h01;
    step(1);
    fault_evt = '0;
    step(3);
    `CHK(interrupt_n, 1'b0)
    wr(ADDR_MASK, 8'h03);
    step(2);
    `CHK(interrupt_n, 1'b1)
    rd(ADDR_FLAGS, d);
    `CHK(d, 8'h02)
  endtask
  task automatic t_lowpower();
    low_power_select = 1'b1;
    step(5);
    `CHK(low_power_active, 1'b1)
    low_power_select = 1'b0;
    step(5);
    `CHK(low_power_active, 1'b0)
  endtask
  // the mask left set by t_fault would hide completion unless reset restores it
  task automatic t_modreset();
    module_reset_n = 1'b0;
    step(2);
    module_reset_n = 1'b1;
    step(6);
    `CHK(init_pending_flag, 1'b0)
    module_reset_n = 1'b0;
    step(RMIN + 10);
    `CHK(init_pending_flag, 1'b1)
    module_reset_n = 1'b1;
    step(INIT - 2);
    `CHK(init_pending_flag, 1'b1)
    wait_int(12);
    `CHK(init_pending_flag, 1'b0)
  endtask
  initial begin
    step(10);
    rst_b = 1'b1;
    step(3);
    t_powerup();
    t_select();
    t_read();
    t_burst();
    t_fault();
    t_lowpower();
    t_modreset();
    stop_test();
  end
endmodule
`default_nettype wire
